// file: logic/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// Control word layout and reset value
`define ADC_CTRL_W 12
`define ADC_CHAN_MSB 7
`define ADC_CHAN_LSB 5
`define ADC_MODE_MSB 4
`define ADC_MODE_LSB 3
`define ADC_MASK_SELECT_BIT 2
`define ADC_SEQ_BIT 1
`define ADC_CTRL_RST 12'h000

// Channel mask
`define ADC_MASK_W 8
`define ADC_MASK_RST 8'h00
`define ADC_PAIR_EVEN 8'h55
`define ADC_SEVEN_USE 8'h7F
`define ADC_COMMON_NEG 3'h7

// Conversion timing in conversion-clock periods
`define ADC_CONV_PERIODS 4'hD
`define ADC_LAST_PERIOD 4'hC

`endif

// file: logic/adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_PSEUDO_FOUR = 2'h1,
    MODE_FULL_DIFF = 2'h2,
    MODE_PSEUDO_SEVEN = 2'h3
  } input_mode_e;

  // Code is {sequencer_enable, mask_select}
  typedef enum logic [1:0] {
    SEQ_OFF = 2'h0,
    SEQ_ARM_MASK = 2'h1,
    SEQ_KEEP = 2'h2,
    SEQ_CONSEC = 2'h3
  } seq_code_e;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'h1,
    CONV_BUSY = 2'h2
  } conv_phase_e;

  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] neg;
    logic neg_is_ground;
    logic illegal;
  } mux_sel_s;

  typedef struct packed {
    conv_phase_e phase;
    logic [3:0] periods;
    logic done;
    logic abort;
    logic unsafe;
  } timer_state_s;

  typedef struct packed {
    logic wr_n_m;
    logic wr_n_s;
    logic wr_n_p;
    logic cs_n_m;
    logic cs_n_s;
    logic [11:0] data_m;
    logic [11:0] data_s;
    logic cst_m;
    logic cst_s;
    logic cst_p;
    logic ck_m;
    logic ck_s;
    logic ck_p;
    logic [11:0] ctrl;
    logic [7:0] mask;
    logic arm;
    logic seq_on;
    logic started;
    logic [2:0] ptr;
    logic [2:0] chan;
    mux_sel_s sel;
  } seq_state_s;

endpackage : adc_seq_pkg

// file: logic/channel_decode.sv
`timescale 1ns/100ps
`include "adc_seq_map.svh"

module channel_decode (
  input wire logic [2:0] i_chan,                   // Channel-select value
  input wire adc_seq_pkg::input_mode_e i_mode,     // Input configuration
  output adc_seq_pkg::mux_sel_s o_sel              // Positive and negative mux sides
);

  always_comb begin
    o_sel.pos = i_chan;
    o_sel.neg = i_chan;
    o_sel.neg_is_ground = 1'b0;
    o_sel.illegal = 1'b0;
    unique case (i_mode)
      adc_seq_pkg::MODE_SINGLE: begin
        o_sel.neg_is_ground = 1'b1;
      end
      adc_seq_pkg::MODE_FULL_DIFF,
      adc_seq_pkg::MODE_PSEUDO_FOUR: begin
        o_sel.neg = {i_chan[2:1], ~i_chan[0]};
      end
      adc_seq_pkg::MODE_PSEUDO_SEVEN: begin
        o_sel.neg = `ADC_COMMON_NEG;
        o_sel.illegal = (i_chan == `ADC_COMMON_NEG);
      end
    endcase
  end

endmodule : channel_decode

// file: logic/conv_timer.sv
`timescale 1ns/100ps
`include "adc_seq_map.svh"

module conv_timer (
  input wire logic i_ref_clk,     // System clock
  input wire logic i_rst_b,       // Async reset, active low
  input wire logic i_start,       // Conversion-start falling edge, pulse
  input wire logic i_start_rise,  // Conversion-start rising edge, pulse
  input wire logic i_clk_fall,    // Conversion clock falling edge, pulse
  input wire logic i_clk_high,    // Conversion clock level
  output logic o_busy,            // Conversion in progress
  output logic o_done,            // Conversion completed, pulse
  output logic o_abort,           // Conversion cut short, pulse
  output logic o_unsafe           // Aborted at half period, reprogramming unsafe
);

  adc_seq_pkg::timer_state_s q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.abort = 1'b0;
    if (i_clk_fall || i_start_rise) begin
      d.unsafe = 1'b0;
    end
    unique case (q.phase)
      adc_seq_pkg::CONV_IDLE: begin
        if (i_start) begin
          d.phase = adc_seq_pkg::CONV_BUSY;
          d.periods = 4'h0;
        end
      end
      adc_seq_pkg::CONV_BUSY: begin
        if (i_start) begin
          // A fresh start before the last period ends kills this one
          d.abort = 1'b1;
          d.periods = 4'h0;
          if (q.periods == `ADC_LAST_PERIOD && i_clk_high) begin
            d.unsafe = 1'b1;
          end
        end else if (i_clk_fall) begin
          if (q.periods == `ADC_LAST_PERIOD) begin
            d.done = 1'b1;
            d.phase = adc_seq_pkg::CONV_IDLE;
          end else begin
            d.periods = q.periods + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '{phase: adc_seq_pkg::CONV_IDLE, periods: 4'h0, done: 1'b0,
             abort: 1'b0, unsafe: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign o_busy = (q.phase == adc_seq_pkg::CONV_BUSY);
  assign o_done = q.done;
  assign o_abort = q.abort;
  assign o_unsafe = q.unsafe;

  a_done_after_thirteen: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    q.done |-> $past(q.periods) == `ADC_LAST_PERIOD && $past(i_clk_fall))
    else $error("conversion finished without thirteen clock periods");

endmodule : conv_timer

// file: logic/adc_channel_sequencer.sv
// How it works
// - A conversion needs 13 full conversion-clock periods, otherwise it aborts.
// - Single-ended: channel-select picks positive input, negative side is ground.
// - Fully differential: pairs 0/1..6/7, odd select swaps polarity.
// - Four-pair pseudo mode decodes like fully differential.
// - Seven-input pseudo: input n against input 7; select 7 forbidden.
// - Sequencer off: each conversion uses the last written channel-select.
// - Enable 0, mask-select 1: next write loads data lines 0-7 into mask.
// - Enable 1, mask-select 0: update control bits, sequence keeps running.
// - Both set: convert consecutively from channel 0 to the selected channel.
// - Mask is 8-bit write-only, loaded on strobe rise when armed or by a both-set control write.
// - Mask bit n means input n; host sets each wanted input.
// - Each start steps ascending through selected channels, wrapping round.
// - Sequence runs until a control write with code 0,0 or 0,1.
// - Differential sequences convert each pair once, normal polarity only.
// - Control word is 12 bits, write-only, all zero after reset.
// - Select bits 7..5, configuration 4..3, mask-select 2, enable 1.
// - Start falling edge samples, begins conversion and advances sequencer.
`timescale 1ns/100ps
`include "adc_seq_map.svh"

module adc_channel_sequencer (
  input wire logic i_ref_clk,                    // 100 MHz system clock
  input wire logic i_rst_b,                      // Async reset, active low
  input wire logic i_cs_n,                       // Chip select pin, active low
  input wire logic i_wr_n,                       // Write strobe pin, active low
  input wire logic [11:0] i_data,                // Parallel data lines
  input wire logic i_conversion_start_n,         // Conversion start pin
  input wire logic i_conversion_clock_in,        // Conversion clock pin
  output logic [2:0] o_vin_pos,                  // Positive mux input index
  output logic [2:0] o_vin_neg,                  // Negative mux input index
  output logic o_neg_is_ground,                  // Negative side on analog ground
  output logic o_sel_illegal,                    // Forbidden select in use
  output logic [2:0] o_channel,                  // Channel-select of last conversion
  output logic [11:0] o_control_word,            // Control word contents
  output logic o_sequence_on,                    // Sequencer running
  output logic o_conv_busy,                      // Conversion in progress
  output logic o_conv_done,                      // Conversion complete, pulse
  output logic o_conv_abort,                     // Conversion aborted, pulse
  output logic o_reprogram_unsafe                // Half-period abort not yet cleared
);

  adc_seq_pkg::seq_state_s q, d;

  logic wr_rise;
  logic cst_fall;
  logic cst_rise;
  logic ck_fall;
  logic [7:0] cand;
  logic [2:0] conv_chan;
  adc_seq_pkg::seq_code_e code;
  adc_seq_pkg::input_mode_e mode;
  adc_seq_pkg::mux_sel_s dec_sel;
  logic [2:0] first_cand;
  logic [7:0] consec_mask;

  // First channel set in mask strictly after ptr, wrapping round
  function automatic logic [2:0] next_after(input logic [7:0] m, input logic [2:0] ptr);
    logic [2:0] idx;
    logic found;
    next_after = ptr;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      idx = 3'(ptr + 3'(i));
      if (!found && m[idx]) begin
        next_after = idx;
        found = 1'b1;
      end
    end
  endfunction : next_after

  function automatic logic [7:0] upto_mask(input logic [2:0] last);
    upto_mask = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= last) begin
        upto_mask[i] = 1'b1;
      end
    end
  endfunction : upto_mask

  // Sequencer candidates for a configuration
  function automatic logic [7:0] seq_cand(input logic [7:0] m, input logic [1:0] md);
    unique case (md)
      adc_seq_pkg::MODE_FULL_DIFF,
      adc_seq_pkg::MODE_PSEUDO_FOUR: begin
        seq_cand = m & {1'b0, m[7:1]} & `ADC_PAIR_EVEN;
      end
      adc_seq_pkg::MODE_PSEUDO_SEVEN: begin
        seq_cand = m & `ADC_SEVEN_USE;
      end
      default: begin
        seq_cand = m;
      end
    endcase
  endfunction : seq_cand

  // Pins come through two flops; edges look only at the second and third stage
  assign wr_rise = q.wr_n_s && !q.wr_n_p && !q.cs_n_s;
  assign cst_fall = !q.cst_s && q.cst_p;
  assign cst_rise = q.cst_s && !q.cst_p;
  assign ck_fall = !q.ck_s && q.ck_p;
  assign mode = adc_seq_pkg::input_mode_e'(q.ctrl[`ADC_MODE_MSB:`ADC_MODE_LSB]);
  assign code = adc_seq_pkg::seq_code_e'({q.data_s[`ADC_SEQ_BIT], q.data_s[`ADC_MASK_SELECT_BIT]});
  assign cand = seq_cand(q.mask, q.ctrl[`ADC_MODE_MSB:`ADC_MODE_LSB]);
  // Kept as nets so the assertions can look back at them one cycle later
  assign first_cand = next_after(cand, 3'h7);
  assign consec_mask = upto_mask(q.data_s[`ADC_CHAN_MSB:`ADC_CHAN_LSB]);

  always_comb begin
    conv_chan = q.ctrl[`ADC_CHAN_MSB:`ADC_CHAN_LSB];
    if (q.seq_on && cand != 8'h00) begin
      conv_chan = next_after(cand, q.started ? q.ptr : 3'h7);
    end
  end

  channel_decode u_decode (
    .i_chan(conv_chan),
    .i_mode(mode),
    .o_sel(dec_sel)
  );

  always_comb begin
    d = q;
    d.wr_n_m = i_wr_n;
    d.wr_n_s = q.wr_n_m;
    d.wr_n_p = q.wr_n_s;
    d.cs_n_m = i_cs_n;
    d.cs_n_s = q.cs_n_m;
    d.data_m = i_data;
    d.data_s = q.data_m;
    d.cst_m = i_conversion_start_n;
    d.cst_s = q.cst_m;
    d.cst_p = q.cst_s;
    d.ck_m = i_conversion_clock_in;
    d.ck_s = q.ck_m;
    d.ck_p = q.ck_s;
    // A start in the same cycle as a write uses the settings before the write
    if (cst_fall) begin
      d.chan = conv_chan;
      d.sel = dec_sel;
      if (q.seq_on && cand != 8'h00) begin
        d.ptr = conv_chan;
        d.started = 1'b1;
      end
    end
    if (wr_rise) begin
      if (q.arm) begin
        d.mask = q.data_s[7:0];
        d.arm = 1'b0;
        d.seq_on = 1'b1;
        d.started = 1'b0;
      end else begin
        d.ctrl = q.data_s;
        d.arm = (code == adc_seq_pkg::SEQ_ARM_MASK);
        unique case (code)
          adc_seq_pkg::SEQ_KEEP: begin
            d.seq_on = q.seq_on;
          end
          adc_seq_pkg::SEQ_CONSEC: begin
            d.mask = upto_mask(q.data_s[`ADC_CHAN_MSB:`ADC_CHAN_LSB]);
            d.seq_on = 1'b1;
            d.started = 1'b0;
          end
          adc_seq_pkg::SEQ_OFF,
          adc_seq_pkg::SEQ_ARM_MASK: begin
            d.seq_on = 1'b0;
            d.started = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
      q.wr_n_m <= 1'b1;
      q.wr_n_s <= 1'b1;
      q.wr_n_p <= 1'b1;
      q.cs_n_m <= 1'b1;
      q.cs_n_s <= 1'b1;
      q.cst_m <= 1'b1;
      q.cst_s <= 1'b1;
      q.cst_p <= 1'b1;
      q.ctrl <= `ADC_CTRL_RST;
      q.mask <= `ADC_MASK_RST;
      q.sel.neg_is_ground <= 1'b1;
    end else begin
      q <= d;
    end
  end

  conv_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_start(cst_fall),
    .i_start_rise(cst_rise),
    .i_clk_fall(ck_fall),
    .i_clk_high(q.ck_s),
    .o_busy(o_conv_busy),
    .o_done(o_conv_done),
    .o_abort(o_conv_abort),
    .o_unsafe(o_reprogram_unsafe)
  );

  assign o_vin_pos = q.sel.pos;
  assign o_vin_neg = q.sel.neg;
  assign o_neg_is_ground = q.sel.neg_is_ground;
  assign o_sel_illegal = q.sel.illegal;
  assign o_channel = q.chan;
  assign o_control_word = q.ctrl;
  assign o_sequence_on = q.seq_on;

  a_mask_load: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_rise && q.arm |=> q.mask == $past(q.data_s[7:0]) && !q.arm && q.seq_on)
    else $error("mask not loaded on armed write");

  a_mask_unarmed: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_rise && !q.arm && code != adc_seq_pkg::SEQ_CONSEC |=> $stable(q.mask))
    else $error("mask changed without arming");

  a_keep_sequence: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_rise && !q.arm && code == adc_seq_pkg::SEQ_KEEP |=>
      q.seq_on == $past(q.seq_on) && q.ctrl == $past(q.data_s))
    else $error("keep write disturbed the sequence");

  a_stop_sequence: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_rise && !q.arm && (code == adc_seq_pkg::SEQ_OFF || code == adc_seq_pkg::SEQ_ARM_MASK)
      |=> !q.seq_on)
    else $error("sequence survived a stopping write");

  a_single_ground: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall && mode == adc_seq_pkg::MODE_SINGLE |=> o_neg_is_ground && o_vin_pos == o_channel)
    else $error("single-ended negative side not grounded");

  a_diff_pairing: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall && mode == adc_seq_pkg::MODE_FULL_DIFF |=>
      !o_neg_is_ground && o_vin_neg == (o_vin_pos ^ 3'h1))
    else $error("differential pair decoded wrongly");

  a_seven_common: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall && mode == adc_seq_pkg::MODE_PSEUDO_SEVEN |=> o_vin_neg == `ADC_COMMON_NEG)
    else $error("seven-input negative side not on input 7");

  a_seq_even: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall && q.seq_on && cand != 8'h00 && mode[1] != mode[0] |=> !o_vin_pos[0])
    else $error("differential sequence used swapped polarity");

  a_seq_fixed: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall && !q.seq_on |=> o_channel == $past(q.ctrl[`ADC_CHAN_MSB:`ADC_CHAN_LSB]))
    else $error("unsequenced conversion ignored channel-select");

  a_seq_ascend: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall && q.seq_on && q.started && cand != 8'h00 |=>
      q.ptr > $past(q.ptr) || q.ptr == $past(first_cand))
    else $error("sequencer did not step upward or wrap");

  // The control word takes the whole strobed word, unused bits included
  a_ctrl_store: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_rise && !q.arm |=> q.ctrl == $past(q.data_s))
    else $error("control word not stored on write");

  // An armed write goes to the mask only, never to the control word
  a_ctrl_kept: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_rise && q.arm |=> $stable(q.ctrl))
    else $error("mask write changed the control word");

  a_arm_mask: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_rise && !q.arm && code == adc_seq_pkg::SEQ_ARM_MASK |=> q.arm && !q.seq_on)
    else $error("arming write did not arm the mask");

  a_consec_mask: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_rise && !q.arm && code == adc_seq_pkg::SEQ_CONSEC |=>
      q.mask == $past(consec_mask) && q.seq_on && !q.started)
    else $error("consecutive sequence not set up from channel 0");

  // First start after a mask load must land on the lowest candidate
  a_seq_first: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall && q.seq_on && !q.started && cand != 8'h00 |=> o_channel == $past(first_cand))
    else $error("sequence did not begin at its lowest channel");

  a_start_chan: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall |=> o_channel == $past(conv_chan) && o_conv_busy)
    else $error("start edge did not latch the channel");

  a_pseudo_pairing: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall && mode == adc_seq_pkg::MODE_PSEUDO_FOUR |=>
      !o_neg_is_ground && o_vin_neg == (o_vin_pos ^ 3'h1))
    else $error("pseudo pair decoded wrongly");

  // Select 7 is a host mistake; the flag lets the system notice it
  a_seven_flag: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    cst_fall && mode == adc_seq_pkg::MODE_PSEUDO_SEVEN |=>
      o_sel_illegal == (o_vin_pos == `ADC_COMMON_NEG))
    else $error("forbidden select not flagged");

endmodule : adc_channel_sequencer

// file: verif/host_port_model.sv
`timescale 1ns/100ps

module host_port_model (
  input wire logic i_ref_clk,      // Bench clock
  output logic o_cs_n,             // Chip select
  output logic o_wr_n,             // Write strobe
  output logic [11:0] o_data,      // Data lines
  output logic o_start_n,          // Conversion start
  output logic o_conv_clk          // Conversion clock
);
  // Released bus shows the inverse of the last word, so stale data never looks valid
  initial begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_data = 12'hFFF;
    o_start_n = 1'b1;
    o_conv_clk = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick

  task automatic write_word(input logic [11:0] w);
    tick(1);
    o_cs_n = 1'b0;
    o_data = w;
    tick(2);
    o_wr_n = 1'b0;
    tick(4);
    o_wr_n = 1'b1;
    tick(4);
    o_cs_n = 1'b1;
    o_data = ~w;
    tick(6);
  endtask : write_word

  // Split so the bench can look between the two edges of one start pulse
  task automatic start_fall();
    tick(1);
    o_start_n = 1'b0;
    tick(4);
  endtask : start_fall

  task automatic start_rise();
    o_start_n = 1'b1;
    tick(6);
  endtask : start_rise

  task automatic start_conv();
    start_fall();
    start_rise();
  endtask : start_conv

  // Clock stands still between frames; a final fall clears a half-period abort
  task automatic conv_edge(input logic lvl);
    o_conv_clk = lvl;
    tick(4);
  endtask : conv_edge

  task automatic conv_periods(input int n);
    repeat (n) begin
      conv_edge(1'b1);
      conv_edge(1'b0);
    end
  endtask : conv_periods
endmodule : host_port_model

// file: verif/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs_n;
  logic wr_n;
  logic start_n;
  logic conv_clk;
  logic [11:0] data;
  logic [11:0] ctrl;
  logic [2:0] pos;
  logic [2:0] neg;
  logic [2:0] chan;
  logic gnd;
  logic illegal;
  logic seq_on;
  logic busy;
  logic done;
  logic abort;
  logic unsafe;
  int dones = 0;
  int aborts = 0;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;

  host_port_model host (.i_ref_clk(ref_clk), .o_cs_n(cs_n), .o_wr_n(wr_n),
    .o_data(data), .o_start_n(start_n), .o_conv_clk(conv_clk));

  adc_channel_sequencer dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_cs_n(cs_n),
    .i_wr_n(wr_n), .i_data(data), .i_conversion_start_n(start_n),
    .i_conversion_clock_in(conv_clk), .o_vin_pos(pos), .o_vin_neg(neg),
    .o_neg_is_ground(gnd), .o_sel_illegal(illegal), .o_channel(chan),
    .o_control_word(ctrl), .o_sequence_on(seq_on), .o_conv_busy(busy),
    .o_conv_done(done), .o_conv_abort(abort), .o_reprogram_unsafe(unsafe));

  // Pulses are one cycle wide; counted mid-cycle, where they have settled
  always @(negedge ref_clk) begin
    cycles++;
    if (done === 1'b1) dones++;
    if (abort === 1'b1) aborts++;
    if (cycles == 30000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input logic [2:0] c);
    host.start_conv();
    check(12'(chan), 12'(c));
  endtask : step

  task automatic t_reset();
    check(ctrl, 12'h000);
    check(12'(gnd), 12'h001);
    check(12'(seq_on), 12'h000);
    check(12'(busy), 12'h000);
  endtask : t_reset

  task automatic t_decode();
    logic [11:0] w;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 8; c++) begin
        w = {4'(c), 3'(c), 2'(m), 2'h0, 1'(m)};
        host.write_word(w);
        check(ctrl, w);
        host.start_conv();
        check(12'(chan), 12'(c));
        if (!(m == 3 && c == 7)) check(12'(pos), 12'(c));
        check(12'(gnd), 12'(m == 0));
        if (m == 1) check(12'(neg), 12'(c ^ 1));
        if (m == 2) check(12'(neg), 12'(c ^ 1));
        if (m == 3) check(12'(illegal), 12'(c == 7));
        if (m == 3 && c != 7) check(12'(neg), 12'h007);
      end
    end
  endtask : t_decode

  task automatic t_timing();
    int d;
    int a;
    host.start_conv();
    check(12'(busy), 12'h001);
    host.conv_periods(12);
    d = dones;
    check(12'(busy), 12'h001);
    host.conv_periods(1);
    check(12'(dones - d), 12'h001);
    check(12'(busy), 12'h000);
    // First pass clears the hazard with a start rise, second with a clock fall
    for (int k = 0; k < 2; k++) begin
      host.start_conv();
      host.conv_periods(12);
      host.conv_edge(1'b1);
      a = aborts;
      host.start_fall();
      check(12'(aborts - a), 12'h001);
      check(12'(unsafe), 12'h001);
      if (k == 0) host.start_rise();
      else host.conv_edge(1'b0);
      check(12'(unsafe), 12'h000);
      if (k == 1) host.start_rise();
    end
  endtask : t_timing

  task automatic t_midreset();
    host.tick(1);
    rst_b = 1'b0;
    host.tick(2);
    check(ctrl, 12'h000);
    check(12'(seq_on), 12'h000);
    check(12'(gnd), 12'h001);
    check(12'(busy), 12'h000);
    rst_b = 1'b1;
    host.tick(2);
    host.write_word(12'h0A0);
    check(ctrl, 12'h0A0);
    step(3'h5);
  endtask : t_midreset

  task automatic t_sequence();
    host.write_word(12'h004);
    host.write_word(12'h025);
    check(ctrl, 12'h004);
    check(12'(seq_on), 12'h001);
    step(3'h0);
    step(3'h2);
    step(3'h5);
    step(3'h0);
    host.write_word(12'h0E2);
    step(3'h2);
    host.write_word(12'h060);
    step(3'h3);
    check(12'(seq_on), 12'h000);
  endtask : t_sequence

  task automatic t_diff();
    host.write_word(12'h014);
    host.write_word(12'h03C);
    step(3'h2);
    check(12'(neg), 12'h003);
    step(3'h4);
    check(12'(neg), 12'h005);
    step(3'h2);
  endtask : t_diff

  task automatic t_consec();
    host.write_word(12'h046);
    check(12'(seq_on), 12'h001);
    step(3'h0);
    step(3'h1);
    step(3'h2);
    step(3'h0);
  endtask : t_consec

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    host.tick(2);
    t_reset();
    t_decode();
    t_timing();
    t_sequence();
    t_diff();
    t_consec();
    t_midreset();
    end_of_test();
  end
endmodule : tb_top
